// >>> pkg/pbs_pkg.sv
package pbs_pkg;

  // Debounce interval and derived cycle count at 100 MHz
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned DEBOUNCE_MS = 24;
  localparam int unsigned DEBOUNCE_CYCLES = DEBOUNCE_MS * 1000 * CLK_MHZ;
  localparam int CNT_W = 32;

  // AXI4-Lite register byte addresses
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] STATUS_ADDR = 8'h04;

  // Control register fields
  localparam int CTRL_FIXED_FREQ_BIT = 0;
  localparam int CTRL_HOLD_BIT = 1;
  localparam int CTRL_EN1_BIT = 2;
  localparam int CTRL_EN2_BIT = 3;
  localparam int CTRL_EN3_BIT = 4;
  localparam logic [31:0] CTRL_RESET = 32'h0000001C;
  localparam logic [31:0] CTRL_MASK = 32'h0000001F;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Sequencer states
  typedef enum logic [2:0] {
    PBS_STANDBY,
    PBS_RUN1,
    PBS_RUN2,
    PBS_RUN3,
    PBS_RESET_WAIT,
    PBS_ON,
    PBS_DISCHARGE
  } pbs_state_type;

  // Converter controls carried together
  typedef struct packed {
    logic step_down_one_enable;
    logic step_down_two_enable;
    logic buck_boost_enable;
    logic protected_switched_output;
    logic discharge;
  } pbs_rail_type;

  // Converter mode per channel
  typedef struct packed {
    logic fixed_freq;
    logic auto_switch;
    logic skip_only;
  } pbs_mode_type;

endpackage

// >>> verilog/pbs_sequencer.sv
// Functional notes
// - Mode high forces fixed-frequency on all converters
// - Mode low allows pulse-skipping; buck-boost skip-only
// - Mode low lets step-downs auto switch
// - Hold input high keeps the device enabled
// - Button low starts sequence and host reset
// - Open-drain debounced status mirrors the button
// - Reset held until regulation plus timed interval
// - Reset held during fault or when disabled
// - Switched output closes after buck-boost regulation
// - Each converter runs only with its enable
// - Low-dropout rail on whenever supply present
// - Tracking rail on whenever supply present
// - Press valid after low for debounce interval
// - Debounced press drives status low, enables first
// - Second after first good, third after second
// - No hold at release disables and discharges
`timescale 1ns/10ps
`default_nettype none
module pbs_sequencer #(
  parameter int unsigned DEBOUNCE_CYCLES = pbs_pkg::DEBOUNCE_CYCLES
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic pushbutton_in_i,
  input wire logic supply_present_i,
  input wire logic fault_i,
  input wire logic step_down_one_good_i,
  input wire logic step_down_two_good_i,
  input wire logic buck_boost_good_i,
  input wire logic reset_threshold_reached_i,
  output logic button_status_out_o,
  output logic button_status_out_oe_o,
  output logic host_reset_n_o,
  output logic reset_timing_capacitor_charge_o,
  output pbs_pkg::pbs_rail_type rails_o,
  output pbs_pkg::pbs_mode_type mode_one_o,
  output pbs_pkg::pbs_mode_type mode_two_o,
  output pbs_pkg::pbs_mode_type mode_three_o,
  output logic ldo_enable_o,
  output logic max_rail_enable_o,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  logic [31:0] ctrl;
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [pbs_pkg::CNT_W-1:0] db_count;
  logic pressed;
  logic pressed_q;
  pbs_pkg::pbs_state_type state;
  pbs_pkg::pbs_state_type next_state;
  logic enabled;
  logic fixed_freq;
  logic hold;
  logic en1;
  logic en2;
  logic en3;
  logic [31:0] status_word;

  assign fixed_freq = ctrl[pbs_pkg::CTRL_FIXED_FREQ_BIT];
  assign hold = ctrl[pbs_pkg::CTRL_HOLD_BIT];
  assign en1 = ctrl[pbs_pkg::CTRL_EN1_BIT];
  assign en2 = ctrl[pbs_pkg::CTRL_EN2_BIT];
  assign en3 = ctrl[pbs_pkg::CTRL_EN3_BIT];

  // Write channel: address and data taken in either order
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= pbs_pkg::RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (aw_held && w_held)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr == pbs_pkg::CTRL_ADDR || aw_addr == pbs_pkg::STATUS_ADDR)
          ? pbs_pkg::RESP_OKAY : pbs_pkg::RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Control register; only the low byte holds fields
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      ctrl <= pbs_pkg::CTRL_RESET;
    end
    else if (aw_held && w_held && aw_addr == pbs_pkg::CTRL_ADDR && w_strb[0])
    begin
      ctrl <= w_data & pbs_pkg::CTRL_MASK;
    end
  end

  // Read channel, one read outstanding
  assign s_axi_arready = !s_axi_rvalid;
  assign status_word = {20'h00000, 1'b0, state, pressed, host_reset_n_o,
    rails_o.discharge, rails_o.protected_switched_output, rails_o.buck_boost_enable,
    rails_o.step_down_two_enable, rails_o.step_down_one_enable, enabled};
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= pbs_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= pbs_pkg::RESP_OKAY;
      if (s_axi_araddr == pbs_pkg::CTRL_ADDR)
      begin
        s_axi_rdata <= ctrl;
      end
      else if (s_axi_araddr == pbs_pkg::STATUS_ADDR)
      begin
        s_axi_rdata <= status_word;
      end
      else
      begin
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= pbs_pkg::RESP_SLVERR;
      end
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Debounce: press and release both need a full quiet interval
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      db_count <= '0;
      pressed <= 1'b0;
    end
    else if ((!pushbutton_in_i) == pressed)
    begin
      db_count <= '0;
    end
    else if (db_count >= DEBOUNCE_CYCLES - 1)
    begin
      db_count <= '0;
      pressed <= !pushbutton_in_i;
    end
    else
    begin
      db_count <= db_count + 1'b1;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      pressed_q <= 1'b0;
    end
    else
    begin
      pressed_q <= pressed;
    end
  end

  // Status pin pulls low while the debounced press stands
  assign button_status_out_o = 1'b0;
  assign button_status_out_oe_o = pressed;

  // Sequencer; good inputs come in already synchronised
  always_comb
  begin
    next_state = state;
    case (state)
      pbs_pkg::PBS_STANDBY:
        if (pressed || hold) next_state = pbs_pkg::PBS_RUN1;
      pbs_pkg::PBS_RUN1:
        if (!en1 || step_down_one_good_i) next_state = pbs_pkg::PBS_RUN2;
      pbs_pkg::PBS_RUN2:
        if (!en2 || step_down_two_good_i) next_state = pbs_pkg::PBS_RUN3;
      pbs_pkg::PBS_RUN3:
        if (!en3 || buck_boost_good_i) next_state = pbs_pkg::PBS_RESET_WAIT;
      pbs_pkg::PBS_RESET_WAIT:
        if (reset_threshold_reached_i) next_state = pbs_pkg::PBS_ON;
      pbs_pkg::PBS_ON:
        next_state = pbs_pkg::PBS_ON;
      pbs_pkg::PBS_DISCHARGE:
        if (!pressed && !hold) next_state = pbs_pkg::PBS_STANDBY;
      default:
        next_state = pbs_pkg::PBS_STANDBY;
    endcase
    // Release without hold, or hold dropped with no press, shuts down
    if (state != pbs_pkg::PBS_STANDBY && state != pbs_pkg::PBS_DISCHARGE)
    begin
      if ((pressed_q && !pressed && !hold) || (!pressed && !hold))
      begin
        next_state = pbs_pkg::PBS_DISCHARGE;
      end
    end
    if (!supply_present_i)
    begin
      next_state = pbs_pkg::PBS_STANDBY;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      state <= pbs_pkg::PBS_STANDBY;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign enabled = state != pbs_pkg::PBS_STANDBY && state != pbs_pkg::PBS_DISCHARGE;

  // Rail enables registered; each gated by its own enable bit
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      rails_o <= '0;
      host_reset_n_o <= 1'b0;
      reset_timing_capacitor_charge_o <= 1'b0;
    end
    else
    begin
      rails_o.step_down_one_enable <= en1 && next_state inside {pbs_pkg::PBS_RUN1,
        pbs_pkg::PBS_RUN2, pbs_pkg::PBS_RUN3, pbs_pkg::PBS_RESET_WAIT,
        pbs_pkg::PBS_ON};
      rails_o.step_down_two_enable <= en2 && next_state inside {pbs_pkg::PBS_RUN2,
        pbs_pkg::PBS_RUN3, pbs_pkg::PBS_RESET_WAIT, pbs_pkg::PBS_ON};
      rails_o.buck_boost_enable <= en3 && next_state inside {pbs_pkg::PBS_RUN3,
        pbs_pkg::PBS_RESET_WAIT, pbs_pkg::PBS_ON};
      rails_o.protected_switched_output <= en3 && buck_boost_good_i
        && next_state inside {pbs_pkg::PBS_RESET_WAIT, pbs_pkg::PBS_ON};
      rails_o.discharge <= next_state == pbs_pkg::PBS_DISCHARGE;
      reset_timing_capacitor_charge_o <= next_state inside {pbs_pkg::PBS_RESET_WAIT,
        pbs_pkg::PBS_ON};
      host_reset_n_o <= next_state == pbs_pkg::PBS_ON && !fault_i;
    end
  end

  // Mode select: fixed frequency wins; buck-boost otherwise skip only
  always_comb
  begin
    mode_one_o = '{fixed_freq: fixed_freq, auto_switch: !fixed_freq, skip_only: 1'b0};
    mode_two_o = '{fixed_freq: fixed_freq, auto_switch: !fixed_freq, skip_only: 1'b0};
    mode_three_o = '{fixed_freq: fixed_freq, auto_switch: 1'b0, skip_only: !fixed_freq};
  end

  // Always-alive rails ignore every enable and the button
  assign ldo_enable_o = supply_present_i;
  assign max_rail_enable_o = supply_present_i;

  a_reset_when_off: assert property (@(posedge clock_i) disable iff (rst_i)
    !enabled |=> !host_reset_n_o) else $error("host reset released while off");
  a_hso_after_good: assert property (@(posedge clock_i) disable iff (rst_i)
    $rose(rails_o.protected_switched_output) |-> $past(buck_boost_good_i))
    else $error("switched output closed before regulation");
  a_bb_skip_mode: assert property (@(posedge clock_i) disable iff (rst_i)
    !fixed_freq |-> mode_three_o.skip_only && !mode_three_o.fixed_freq)
    else $error("buck-boost not skip-only");
  a_en_gating: assert property (@(posedge clock_i) disable iff (rst_i)
    !en2 |=> !rails_o.step_down_two_enable) else $error("disabled converter ran");
  a_release_no_hold: assert property (@(posedge clock_i) disable iff (rst_i)
    enabled && pressed_q && !pressed && !hold && supply_present_i |=> rails_o.discharge)
    else $error("release without hold not shut down");
  a_status_mirror: assert property (@(posedge clock_i) disable iff (rst_i)
    $changed(button_status_out_oe_o) |-> button_status_out_oe_o == !$past(pushbutton_in_i))
    else $error("status does not mirror press");
  a_ldo_on: assert property (@(posedge clock_i) disable iff (rst_i)
    supply_present_i |-> ldo_enable_o && max_rail_enable_o) else $error("always-alive rail off");
  a_first_rail: assert property (@(posedge clock_i) disable iff (rst_i)
    state == pbs_pkg::PBS_STANDBY && pressed && en1 && supply_present_i
    |=> rails_o.step_down_one_enable) else $error("first converter not enabled");
  a_reset_timed: assert property (@(posedge clock_i) disable iff (rst_i)
    $rose(host_reset_n_o) |-> $past(reset_threshold_reached_i) || $past(state) == pbs_pkg::PBS_ON)
    else $error("reset released early");

  c_power_up: cover property (@(posedge clock_i) $rose(host_reset_n_o));
  c_discharge: cover property (@(posedge clock_i) $rose(rails_o.discharge));
  c_skip_two: cover property (@(posedge clock_i) state == pbs_pkg::PBS_RUN2 && !en2);

endmodule
`default_nettype wire

// >>> tb/pbs_partner.sv
`timescale 1ns/10ps
`default_nettype none
module pbs_partner (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic press_i,
  input wire pbs_pkg::pbs_rail_type rails_i,
  input wire logic charge_i,
  output logic button_o,
  output logic [2:0] good_o,
  output logic thr_o
);
  logic [2:0] d1, d2, d3, dc;
  // Key to ground when pressed, pulled high when released
  assign button_o = ~press_i;
  // Rails settle three cycles after enable, drop with it
  always_ff @(posedge clock_i)
  begin
    d1 <= rst_i ? 3'h0 : {d1[1:0], rails_i.step_down_one_enable};
    d2 <= rst_i ? 3'h0 : {d2[1:0], rails_i.step_down_two_enable};
    d3 <= rst_i ? 3'h0 : {d3[1:0], rails_i.buck_boost_enable};
    dc <= rst_i ? 3'h0 : {dc[1:0], charge_i};
  end
  // Comparator results handed over as plain levels
  assign good_o[2] = &d1 & rails_i.step_down_one_enable;
  assign good_o[1] = &d2 & rails_i.step_down_two_enable;
  assign good_o[0] = &d3 & rails_i.buck_boost_enable;
  assign thr_o = &dc & charge_i;
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clock_i = 0, rst_i = 1, press = 0, supply = 1, fault = 0;
  logic [2:0] good;
  logic bso_in;
  logic thr, bso, oe, hr, chg, ldo, mx, awready, wready, bvalid, arready, rvalid;
  pbs_pkg::pbs_rail_type rails;
  pbs_pkg::pbs_mode_type m1, m2, m3;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, rd;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [1:0] bresp, rresp, resp;
  logic [6:0] obs;
  int err_total = 0, n_checks = 0, cyc = 0, n;
  assign obs = {oe, hr, rails};
  // Short debounce keeps the run brief
  pbs_sequencer #(.DEBOUNCE_CYCLES(8)) dut (.clock_i(clock_i), .rst_i(rst_i),
    .pushbutton_in_i(bso_in), .supply_present_i(supply), .fault_i(fault),
    .step_down_one_good_i(good[2]), .step_down_two_good_i(good[1]),
    .buck_boost_good_i(good[0]), .reset_threshold_reached_i(thr),
    .button_status_out_o(bso), .button_status_out_oe_o(oe), .host_reset_n_o(hr),
    .reset_timing_capacitor_charge_o(chg), .rails_o(rails), .mode_one_o(m1),
    .mode_two_o(m2), .mode_three_o(m3), .ldo_enable_o(ldo), .max_rail_enable_o(mx),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  pbs_partner partner (.clock_i(clock_i), .rst_i(rst_i), .press_i(press),
    .rails_i(rails), .charge_i(chg), .button_o(bso_in), .good_o(good), .thr_o(thr));
  // Clock and hang guard
  always #5 clock_i = ~clock_i;
  always @(posedge clock_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      finish_test();
    end
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e)
    begin
      err_total++;
      $display("wrong value t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic finish_test();
    if (err_total == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Bounded wait for one observed output bit
  task automatic wt(input int i, input logic v, output int c);
    c = 0;
    while (obs[i] !== v && c < 100)
    begin
      @(posedge clock_i);
      c++;
    end
  endtask
  // Write: address and data offered together, each dropped once taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    bit aw, w, b;
    aw = 0;
    w = 0;
    b = 0;
    @(posedge clock_i);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (!b)
    begin
      @(posedge clock_i);
      if (aw && w && bvalid)
      begin
        b = 1;
        r = bresp;
        bready <= 0;
      end
      if (!aw && awready)
      begin
        aw = 1;
        awvalid <= 0;
      end
      if (!w && wready)
      begin
        w = 1;
        wvalid <= 0;
      end
    end
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    bit ar, v;
    ar = 0;
    v = 0;
    @(posedge clock_i);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    while (!v)
    begin
      @(posedge clock_i);
      if (ar && rvalid)
      begin
        v = 1;
        d = rdata;
        r = rresp;
        rready <= 0;
      end
      if (!ar && arready)
      begin
        ar = 1;
        arvalid <= 0;
      end
    end
  endtask
  // Reset state, register map edges
  task automatic t_reset();
    chk(obs, 7'h00);
    axr(8'h00, rd, resp);
    chk(rd, pbs_pkg::CTRL_RESET);
    axr(8'h08, rd, resp);
    chk(resp, pbs_pkg::RESP_SLVERR);
    axw(8'h08, 32'h0, resp);
    chk(resp, pbs_pkg::RESP_SLVERR);
    axw(8'h04, 32'h0, resp);
    chk(resp, pbs_pkg::RESP_OKAY);
  endtask
  // Both mode settings, always-alive rails follow supply
  task automatic t_mode();
    axw(8'h00, 32'h1D, resp);
    chk({m1, m2, m3}, 9'h124);
    axw(8'h00, 32'h1C, resp);
    chk({m1, m2, m3}, 9'h091);
    supply <= 0;
    @(posedge clock_i);
    @(posedge clock_i);
    chk({ldo, mx}, 2'h0);
    supply <= 1;
    @(posedge clock_i);
    @(posedge clock_i);
    chk({ldo, mx}, 2'h3);
  endtask
  // Glitch, full press, ordered power-up, hold, fault, shutdown
  task automatic t_up();
    press <= 1;
    repeat (6) @(posedge clock_i);
    press <= 0;
    repeat (4) @(posedge clock_i);
    chk(obs, 7'h00);
    press <= 1;
    wt(6, 1, n);
    chk(n >= 8 && n <= 12, 1);
    wt(4, 1, n);
    chk(n <= 1, 1);
    chk(hr, 0);
    wt(3, 1, n);
    chk(good[2], 1);
    wt(2, 1, n);
    chk(good[1], 1);
    wt(1, 1, n);
    chk(good[0], 1);
    chk(chg, 1);
    chk(hr, 0);
    wt(5, 1, n);
    chk(thr && n < 100, 1);
    axw(8'h00, 32'h1E, resp);
    press <= 0;
    wt(6, 0, n);
    chk(n <= 12, 1);
    repeat (4) @(posedge clock_i);
    chk(obs, 7'h3E);
    chk(bso, 0);
    axr(8'h04, rd, resp);
    chk(rd, 32'h0000055F);
    fault <= 1;
    repeat (3) @(posedge clock_i);
    chk(hr, 0);
    fault <= 0;
    axw(8'h00, 32'h1C, resp);
    wt(4, 0, n);
    chk(n < 100 && hr === 1'b0, 1);
  endtask
  // Second converter skipped, release without hold discharges
  task automatic t_skip();
    axw(8'h00, 32'h14, resp);
    press <= 1;
    wt(2, 1, n);
    chk(rails.step_down_two_enable, 0);
    chk(good[2], 1);
    press <= 0;
    wt(0, 1, n);
    chk(n <= 20, 1);
    wt(4, 0, n);
    chk(obs[5], 0);
    axw(8'h00, 32'h1C, resp);
  endtask
  // Main sequence
  initial
  begin
    repeat (12) @(posedge clock_i);
    rst_i <= 0;
    t_reset();
    t_mode();
    t_up();
    t_skip();
    finish_test();
  end
endmodule
`default_nettype wire
